// ### verilog/vafc_regs.vh
// register indices, field layouts, reset values and limits of the video area / fifo config bank
// assumes a 16-bit indirect host port and a 512-entry compressed-data fifo
`ifndef VAFC_REGS_VH
`define VAFC_REGS_VH

`define VAFC_IDX_FIFO_LEVELS 8'h01
`define VAFC_IDX_H_START 8'h02
`define VAFC_IDX_H_END 8'h03
`define VAFC_IDX_V_START 8'h04
`define VAFC_IDX_V_END 8'h05
`define VAFC_IDX_LIMIT_EN 8'h07
`define VAFC_IDX_FIELD_LIMIT 8'h08
`define VAFC_IDX_MODE2 8'h09

`define VAFC_LEVELS_RANGE 7:0
`define VAFC_MODE2_RANGE 11:0
`define VAFC_ESL_RANGE 3:0
`define VAFC_DSL_RANGE 7:4
`define VAFC_COORD_RANGE 9:0
`define VAFC_LIMIT_EN_BIT 4
`define VAFC_CONTRAST_RANGE 2:0
`define VAFC_FIELD_POL_BIT 3
`define VAFC_RATE_RED_RANGE 8:4
`define VAFC_MEMORY_ERROR_FLAG_EN_BIT 9
`define VAFC_RSVD10_BIT 10
`define VAFC_IGNORE_FIELD_BIT 11

`define VAFC_RST_LEVELS 8'h88
`define VAFC_RST_START 10'h000
`define VAFC_RST_END 10'h3ff
`define VAFC_RST_LIMIT_EN 16'h0000
`define VAFC_RST_FIELD_LIMIT 16'hffff
`define VAFC_RST_MODE2 12'h401

`define VAFC_FIFO_DEPTH 11'h200
`define VAFC_LEVEL_SPAN 5'h10
`define VAFC_LEVEL_SHIFT 5
`define VAFC_LIMIT_LSB_ZERO 4'h0

`define VAFC_V_MAX_525 10'h20d
`define VAFC_V_MAX_625 10'h271
`define VAFC_VQB_MAX_525 10'h0f3
`define VAFC_VQB_MAX_625 10'h120
`define VAFC_H_MAX_DEFAULT 10'h2cf

`define VAFC_LUMA_MIN 8'h10
`define VAFC_CHROMA_ZERO 8'h80

`endif

// ### verilog/vafc_axis_window.v
// one axis of the area rectangle: clamps the end to the mode maximum and tests a position
// assumes all inputs come from flops on the same clock; purely combinational
module vafc_axis_window (
  input wire [9:0] start_in,
  input wire [9:0] end_in,
  input wire [9:0] max_in,
  input wire [9:0] pos_in,
  output wire inside_out
);
  wire [9:0] end_eff;
  assign end_eff = (end_in > max_in) ? max_in : end_in;
  assign inside_out = (pos_in >= start_in) && (pos_in <= end_eff) && (start_in <= end_eff);
endmodule // vafc_axis_window

// ### verilog/vafc_config.v
// indirect configuration bank: fifo service levels, area / quality box, field size limit, mode 2
// assumes the main mode bits and video timing come from logic on core_clk_in; field_pin_in is a pin
//
// Function
// - encode request when filled count reaches encode level times 32; zero disables
// - decode request when empty count reaches (16 - decode level) times 32
// - crop mode: samples outside rectangle become minimum luma, zero chroma
// - cropping only while encoding; image size unchanged, samples blacked
// - vertical coordinates count from 1 with blanking, horizontal from 0
// - quality box mode: outside box attenuated; vertical range 243 or 288
// - quality box uses same vertical values for every field
// - horizontal end above mode width uses the mode maximum
// - vertical end above mode line count uses the mode maximum
// - vertical and horizontal start are 10-bit, reset to zero
// - word count reaching limit raises size_limit_reached_out until the next field start, only while encoding with limit enable bit 4 set
// - limit register gives count bits 19:4, low bits zero, resets to ffff
// - 3-bit background contrast sets 6 to 30 dB attenuation; 000 illegal
// - field polarity bit inverts the field indicator; resets normal
// - keep one field, drop next N, repeating; zero keeps all
// - ignore-field bit stops black fields on repeated field indication in decode
// - service request flag follows live condition; pin mirrors it
// - main mode bit 14 selects crop or quality box interpretation
// - main mode bit 6 selects 525 or 625 line limits
`include "vafc_regs.vh"
module vafc_config #(
  parameter [9:0] H_MAX_525 = `VAFC_H_MAX_DEFAULT,
  parameter [9:0] H_MAX_625 = `VAFC_H_MAX_DEFAULT
) (
  input wire core_clk_in,
  input wire arst_n_in,
  input wire ce_in,
  input wire [7:0] host_index_in,
  input wire [15:0] host_wdata_in,
  input wire host_wr_in,
  input wire host_rd_in,
  output wire [15:0] host_rdata_out,
  output wire host_rvalid_out,
  input wire mode_quality_box_enable_in,
  input wire mode_625_line_in,
  input wire mode_encode_in,
  input wire [9:0] fifo_fill_count_in,
  output wire fifo_service_request_flag_out,
  output wire fifo_service_request_pin_out,
  input wire sample_valid_in,
  input wire [9:0] pixel_pos_in,
  input wire [9:0] frame_line_in,
  input wire [9:0] field_line_in,
  input wire [7:0] luma_in,
  input wire [7:0] chroma_in,
  output wire sample_valid_out,
  output wire [7:0] luma_out,
  output wire [7:0] chroma_out,
  output wire outside_box_out,
  output wire [2:0] background_contrast_out,
  input wire field_pin_in,
  input wire field_start_in,
  output wire field_indicator_out,
  output wire field_keep_out,
  output wire decode_black_field_out,
  input wire dword_written_in,
  output wire size_limit_reached_out,
  output wire memory_error_detect_en_out
);
  reg [7:0] levels_ff;
  reg [9:0] h_start_ff;
  reg [9:0] h_end_ff;
  reg [9:0] v_start_ff;
  reg [9:0] v_end_ff;
  reg [15:0] limit_en_ff;
  reg [15:0] field_limit_ff;
  reg [11:0] mode2_ff;
  reg [15:0] rdata_ff;
  reg rvalid_ff;
  reg [15:0] nxt_rdata;
  reg srq_ff;
  reg sample_valid_ff;
  reg [7:0] luma_ff;
  reg [7:0] chroma_ff;
  reg outside_ff;
  reg field_s1_ff;
  reg field_s2_ff;
  reg field_s3_ff;
  reg field_stable_ff;
  reg field_prev_ff;
  reg field_seen_ff;
  reg black_field_ff;
  reg [4:0] drop_cnt_ff;
  reg keep_ff;
  reg [19:0] dword_cnt_ff;
  reg limit_hit_ff;
  reg field_ind_ff;

  wire [3:0] encode_service_level;
  wire [3:0] decode_service_level;
  wire [10:0] fill_ext;
  wire [10:0] empty_cnt;
  wire [10:0] enc_thresh;
  wire [10:0] dec_thresh;
  wire [4:0] dsl_rest;
  wire nxt_srq;
  wire [9:0] h_max;
  wire [9:0] v_max;
  wire [9:0] v_pos;
  wire [19:0] limit_words;
  wire [1:0] axis_inside;
  wire [39:0] axis_bus;
  wire [39:0] axis_pos_bus;
  wire in_rect;
  wire nxt_black;
  wire [4:0] rate_n;
  wire field_repeat;

  // register write port
  always @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      levels_ff <= `VAFC_RST_LEVELS;
      h_start_ff <= `VAFC_RST_START;
      v_start_ff <= `VAFC_RST_START;
      h_end_ff <= `VAFC_RST_END;
      v_end_ff <= `VAFC_RST_END;
      limit_en_ff <= `VAFC_RST_LIMIT_EN;
      field_limit_ff <= `VAFC_RST_FIELD_LIMIT;
      // bit 9 low, bit 10 high
      mode2_ff <= `VAFC_RST_MODE2;
    end
    else if (ce_in && host_wr_in)
    begin
      case (host_index_in)
        `VAFC_IDX_FIFO_LEVELS: levels_ff <= host_wdata_in[`VAFC_LEVELS_RANGE];
        `VAFC_IDX_H_START: h_start_ff <= host_wdata_in[`VAFC_COORD_RANGE];
        `VAFC_IDX_H_END: h_end_ff <= host_wdata_in[`VAFC_COORD_RANGE];
        `VAFC_IDX_V_START: v_start_ff <= host_wdata_in[`VAFC_COORD_RANGE];
        `VAFC_IDX_V_END: v_end_ff <= host_wdata_in[`VAFC_COORD_RANGE];
        `VAFC_IDX_LIMIT_EN: limit_en_ff <= host_wdata_in;
        `VAFC_IDX_FIELD_LIMIT: field_limit_ff <= host_wdata_in;
        `VAFC_IDX_MODE2: mode2_ff <= host_wdata_in[`VAFC_MODE2_RANGE];
        default: levels_ff <= levels_ff;
      endcase
    end
  end

  // area registers are write only and read back zero, as does any unmapped index
  always @*
  begin
    nxt_rdata = 16'h0000;
    case (host_index_in)
      `VAFC_IDX_FIFO_LEVELS: nxt_rdata = {8'h00, levels_ff};
      `VAFC_IDX_LIMIT_EN: nxt_rdata = limit_en_ff;
      `VAFC_IDX_FIELD_LIMIT: nxt_rdata = field_limit_ff;
      `VAFC_IDX_MODE2: nxt_rdata = {4'h0, mode2_ff};
      default: nxt_rdata = 16'h0000;
    endcase
  end

  always @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rdata_ff <= 16'h0000;
      rvalid_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      rvalid_ff <= host_rd_in;
      if (host_rd_in)
      begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign host_rdata_out = rdata_ff;
  assign host_rvalid_out = rvalid_ff;

  // fifo service request thresholds
  assign encode_service_level = levels_ff[`VAFC_ESL_RANGE];
  assign decode_service_level = levels_ff[`VAFC_DSL_RANGE];
  assign fill_ext = {1'b0, fifo_fill_count_in};
  assign empty_cnt = `VAFC_FIFO_DEPTH - fill_ext;
  assign dsl_rest = `VAFC_LEVEL_SPAN - {1'b0, decode_service_level};
  assign enc_thresh = {7'h00, encode_service_level} << `VAFC_LEVEL_SHIFT;
  assign dec_thresh = {6'h00, dsl_rest} << `VAFC_LEVEL_SHIFT;
  assign nxt_srq = mode_encode_in ? ((encode_service_level != 4'h0) && (fill_ext >= enc_thresh)) :
                   ((decode_service_level != 4'h0) && (empty_cnt >= dec_thresh));

  always @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      srq_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      srq_ff <= nxt_srq;
    end
  end

  assign fifo_service_request_flag_out = srq_ff;
  assign fifo_service_request_pin_out = srq_ff;

  assign h_max = mode_625_line_in ? H_MAX_625 : H_MAX_525;
  assign v_max = mode_quality_box_enable_in ?
                 (mode_625_line_in ? `VAFC_VQB_MAX_625 : `VAFC_VQB_MAX_525) :
                 (mode_625_line_in ? `VAFC_V_MAX_625 : `VAFC_V_MAX_525);
  // crop uses frame line from 1
  assign v_pos = mode_quality_box_enable_in ? field_line_in : frame_line_in;

  assign axis_bus = {v_start_ff, v_end_ff, h_start_ff, h_end_ff};
  assign axis_pos_bus = {v_max, v_pos, h_max, pixel_pos_in};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_axis
      vafc_axis_window u_axis (
        .start_in(axis_bus[g*20+19:g*20+10]),
        .end_in(axis_bus[g*20+9:g*20]),
        .max_in(axis_pos_bus[g*20+19:g*20+10]),
        .pos_in(axis_pos_bus[g*20+9:g*20]),
        .inside_out(axis_inside[g])
      );
    end
  endgenerate

  assign in_rect = &axis_inside;
  assign nxt_black = !mode_quality_box_enable_in && mode_encode_in && !in_rect;

  // one-stage sample path; black keeps the sample slot so the image size is unchanged
  always @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      sample_valid_ff <= 1'b0;
      luma_ff <= 8'h00;
      chroma_ff <= 8'h00;
      outside_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      sample_valid_ff <= sample_valid_in;
      if (sample_valid_in)
      begin
        luma_ff <= nxt_black ? `VAFC_LUMA_MIN : luma_in;
        chroma_ff <= nxt_black ? `VAFC_CHROMA_ZERO : chroma_in;
        outside_ff <= mode_quality_box_enable_in && !in_rect;
      end
    end
  end

  assign sample_valid_out = sample_valid_ff;
  assign luma_out = luma_ff;
  assign chroma_out = chroma_ff;
  assign outside_box_out = outside_ff;
  assign background_contrast_out = mode2_ff[`VAFC_CONTRAST_RANGE];
  assign memory_error_detect_en_out = mode2_ff[`VAFC_MEMORY_ERROR_FLAG_EN_BIT];

  // field pin: three flops, accepted only once the last two agree
  always @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      field_s1_ff <= 1'b0;
      field_s2_ff <= 1'b0;
      field_s3_ff <= 1'b0;
      field_stable_ff <= 1'b0;
      field_ind_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      field_s1_ff <= field_pin_in;
      field_s2_ff <= field_s1_ff;
      field_s3_ff <= field_s2_ff;
      if (field_s2_ff == field_s3_ff)
      begin
        field_stable_ff <= field_s3_ff;
      end
      field_ind_ff <= field_stable_ff ^ mode2_ff[`VAFC_FIELD_POL_BIT];
    end
  end

  assign field_indicator_out = field_ind_ff;

  assign rate_n = mode2_ff[`VAFC_RATE_RED_RANGE];
  assign field_repeat = field_seen_ff && (field_stable_ff == field_prev_ff);

  // per-field bookkeeping at each field start
  always @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      drop_cnt_ff <= 5'h00;
      keep_ff <= 1'b1;
      field_prev_ff <= 1'b0;
      field_seen_ff <= 1'b0;
      black_field_ff <= 1'b0;
    end
    else if (ce_in && field_start_in)
    begin
      keep_ff <= (drop_cnt_ff == 5'h00);
      drop_cnt_ff <= (drop_cnt_ff >= rate_n) ? 5'h00 : drop_cnt_ff + 5'h01;
      field_prev_ff <= field_stable_ff;
      field_seen_ff <= 1'b1;
      black_field_ff <= !mode_encode_in && field_repeat && !mode2_ff[`VAFC_IGNORE_FIELD_BIT];
    end
  end

  assign field_keep_out = keep_ff;
  assign decode_black_field_out = black_field_ff;

  assign limit_words = {field_limit_ff, `VAFC_LIMIT_LSB_ZERO};

  // word counter saturates so a runaway field cannot wrap past the limit
  always @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      dword_cnt_ff <= 20'h00000;
      limit_hit_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      if (field_start_in)
      begin
        dword_cnt_ff <= 20'h00000;
        limit_hit_ff <= 1'b0;
      end
      else
      begin
        if (dword_written_in && (dword_cnt_ff != 20'hfffff))
        begin
          dword_cnt_ff <= dword_cnt_ff + 20'h00001;
        end
        limit_hit_ff <= limit_en_ff[`VAFC_LIMIT_EN_BIT] && mode_encode_in && (dword_cnt_ff >= limit_words);
      end
    end
  end

  assign size_limit_reached_out = limit_hit_ff;

endmodule // vafc_config

// ### testbench/vafc_host_model.sv
// host processor model: indirect register writes and reads, one strobe cycle each
// assumes the bank takes strobes on the rising edge and answers a read one cycle later
module vafc_host_model (
  input wire clk_in,
  input wire [15:0] rdata_in,
  input wire rvalid_in,
  output logic [7:0] index_out,
  output logic [15:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    index_out = 8'h00;
    wdata_out = 16'h0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // whole-word writes, caller picks the value
  task write_reg(input [7:0] a, input [15:0] d);
    index_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    // stale data inverted so a late sample cannot match
    wdata_out = ~d;
    @(negedge clk_in);
  endtask
  task read_reg(input [7:0] a, output [15:0] d, output v);
    index_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    rd_out = 1'b0;
    d = rdata_in;
    v = rvalid_in;
    @(negedge clk_in);
  endtask
endmodule // vafc_host_model

// ### testbench/vafc_config_chk.sv
// checker for the config bank, shadowing host writes to predict outputs
// assumes one clock, reset asynchronous active low
module vafc_config_chk (
  input wire core_clk_in,
  input wire arst_n_in,
  input wire ce_in,
  input wire [7:0] host_index_in,
  input wire [15:0] host_wdata_in,
  input wire host_wr_in,
  input wire host_rd_in,
  input wire [15:0] host_rdata_out,
  input wire host_rvalid_out,
  input wire mode_quality_box_enable_in,
  input wire mode_encode_in,
  input wire [9:0] fifo_fill_count_in,
  input wire fifo_service_request_flag_out,
  input wire fifo_service_request_pin_out,
  input wire sample_valid_in,
  input wire [9:0] pixel_pos_in,
  input wire [7:0] luma_in,
  input wire [7:0] chroma_in,
  input wire [7:0] luma_out,
  input wire [7:0] chroma_out,
  input wire [2:0] background_contrast_out,
  input wire field_start_in,
  input wire field_keep_out,
  input wire size_limit_reached_out,
  input wire memory_error_detect_en_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  logic [7:0] lv_ff;
  logic [9:0] hs_ff;
  logic [15:0] lim_ff;
  logic [11:0] m2_ff;
  wire enc_hit = lv_ff[3:0] != 4'h0 && fifo_fill_count_in >= {1'b0, lv_ff[3:0], 5'h00};
  wire dec_hit = lv_ff[7:4] != 4'h0 && fifo_fill_count_in <= {1'b0, lv_ff[7:4], 5'h00};
  wire smp = ce_in && sample_valid_in;
  // shadow copies follow the host writes
  always @(posedge core_clk_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      lv_ff <= 8'h88;
      hs_ff <= 10'h000;
      lim_ff <= 16'hffff;
      m2_ff <= 12'h401;
    end
    else if (ce_in && host_wr_in)
    begin
      if (host_index_in == 8'h01) lv_ff <= host_wdata_in[7:0];
      if (host_index_in == 8'h02) hs_ff <= host_wdata_in[9:0];
      if (host_index_in == 8'h08) lim_ff <= host_wdata_in;
      if (host_index_in == 8'h09) m2_ff <= host_wdata_in[11:0];
    end
  property p_enc;
    ce_in && mode_encode_in |=> fifo_service_request_flag_out == $past(enc_hit);
  endproperty
  a_enc: assert property (p_enc) else $error("encode request wrong");
  property p_dec;
    ce_in && !mode_encode_in |=> fifo_service_request_flag_out == $past(dec_hit);
  endproperty
  a_dec: assert property (p_dec) else $error("decode request wrong");
  property p_pin;
    fifo_service_request_pin_out == fifo_service_request_flag_out;
  endproperty
  a_pin: assert property (p_pin) else $error("pin differs from flag");
  property p_black;
    smp && mode_encode_in && !mode_quality_box_enable_in && pixel_pos_in < hs_ff
      |=> luma_out == 8'h10 && chroma_out == 8'h80;
  endproperty
  a_black: assert property (p_black) else $error("crop sample not black");
  property p_pass;
    smp && (!mode_encode_in || mode_quality_box_enable_in)
      |=> luma_out == $past(luma_in) && chroma_out == $past(chroma_in);
  endproperty
  a_pass: assert property (p_pass) else $error("sample altered");
  property p_rdlim;
    ce_in && host_rd_in && host_index_in == 8'h08 |=> host_rvalid_out && host_rdata_out == $past(lim_ff);
  endproperty
  a_rdlim: assert property (p_rdlim) else $error("limit readback wrong");
  property p_contrast;
    ce_in && host_wr_in && host_index_in == 8'h09 ##1 ce_in |=> background_contrast_out == m2_ff[2:0];
  endproperty
  a_contrast: assert property (p_contrast) else $error("contrast wrong");
  property p_memory_error_flag;
    ce_in && host_wr_in && host_index_in == 8'h09 ##1 ce_in |=> memory_error_detect_en_out == m2_ff[9];
  endproperty
  a_memory_error_flag: assert property (p_memory_error_flag) else $error("error enable wrong");
  property p_keep;
    ce_in && field_start_in && m2_ff[8:4] == 5'h00 |=> field_keep_out;
  endproperty
  a_keep: assert property (p_keep) else $error("field dropped");
  c_req: cover property ($rose(fifo_service_request_flag_out));
  c_blk: cover property (smp && mode_encode_in && pixel_pos_in < hs_ff);
  c_lim: cover property ($rose(size_limit_reached_out));
endmodule // vafc_config_chk

bind vafc_config vafc_config_chk u_vafc_config_chk (.*);

// ### testbench/tb.sv
// self-checking bench for the config bank; host model drives the register port
// assumes default horizontal maximum of 719 for both line modes
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 1'b0, arst_n_in = 1'b0, ce_in = 1'b1, mode_quality_box_enable_in = 1'b0;
  logic mode_625_line_in = 1'b0, mode_encode_in = 1'b1, sample_valid_in = 1'b0, field_pin_in = 1'b0;
  logic field_start_in = 1'b0, dword_written_in = 1'b0;
  logic [9:0] fifo_fill_count_in = 10'h000, pixel_pos_in = 10'h000;
  logic [9:0] frame_line_in = 10'h064, field_line_in = 10'h032;
  logic [7:0] luma_in = 8'h5a, chroma_in = 8'h33, host_index_in, luma_out, chroma_out;
  logic [15:0] host_wdata_in, host_rdata_out, v;
  logic host_wr_in, host_rd_in, host_rvalid_out, fifo_service_request_flag_out, ok;
  logic fifo_service_request_pin_out, sample_valid_out, outside_box_out, field_indicator_out;
  logic field_keep_out, decode_black_field_out, size_limit_reached_out, memory_error_detect_en_out;
  logic [2:0] background_contrast_out;
  integer errors = 0, checks = 0, cyc = 0, i;
  always #2.5 core_clk_in = ~core_clk_in;
  vafc_config u_vafc_config (.*);
  vafc_host_model u_vafc_host_model (.clk_in(core_clk_in), .rdata_in(host_rdata_out),
    .rvalid_in(host_rvalid_out), .index_out(host_index_in), .wdata_out(host_wdata_in),
    .wr_out(host_wr_in), .rd_out(host_rd_in));
  task complete_run;
    if (errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input string n, input [15:0] e, input [15:0] g);
    checks++;
    if (g !== e)
    begin
      $display("unexpected %s exp %h got %h", n, e, g);
      errors++;
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    u_vafc_host_model.write_reg(a, d);
  endtask
  task rd(input [7:0] a, input [15:0] e);
    u_vafc_host_model.read_reg(a, v, ok);
    chk("rvalid", 16'h0001, {15'h0000, ok});
    chk("rdata", e, v);
  endtask
  task fq(input [9:0] f, input e);
    fifo_fill_count_in = f;
    @(negedge core_clk_in);
    chk("flag", {15'h0000, e}, {15'h0000, fifo_service_request_flag_out});
  endtask
  task smp(input [9:0] p, input bl);
    pixel_pos_in = p;
    sample_valid_in = 1'b1;
    @(negedge core_clk_in);
    sample_valid_in = 1'b0;
    chk("svalid", 16'h0001, {15'h0000, sample_valid_out});
    chk("luma", bl ? 16'h0010 : 16'h005a, {8'h00, luma_out});
    chk("chroma", bl ? 16'h0080 : 16'h0033, {8'h00, chroma_out});
    @(negedge core_clk_in);
  endtask
  // one-cycle strobe: 1 pulses field_start_in, 0 pulses dword_written_in
  task pulse(input logic sel);
    if (sel)
      field_start_in = 1'b1;
    else
      dword_written_in = 1'b1;
    @(negedge core_clk_in);
    field_start_in = 1'b0;
    dword_written_in = 1'b0;
    @(negedge core_clk_in);
  endtask
  // hang guard, whole run needs well under a thousand cycles
  always @(posedge core_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      errors++;
      complete_run;
    end
  end
  initial
  begin
    repeat (2) @(negedge core_clk_in);
    arst_n_in = 1'b1;
    @(negedge core_clk_in);
    rd(8'h01, 16'h0088);
    rd(8'h02, 16'h0000);
    rd(8'h03, 16'h0000);
    rd(8'h05, 16'h0000);
    rd(8'h07, 16'h0000);
    rd(8'h08, 16'hffff);
    rd(8'h09, 16'h0401);
    rd(8'h0a, 16'h0000);
    fq(10'h100, 1'b1);
    fq(10'h0ff, 1'b0);
    wr(8'h01, 16'hff13);
    rd(8'h01, 16'h0013);
    fq(10'h05f, 1'b0);
    fq(10'h060, 1'b1);
    mode_encode_in = 1'b0;
    fq(10'h021, 1'b0);
    fq(10'h020, 1'b1);
    wr(8'h01, 16'h0010);
    mode_encode_in = 1'b1;
    fq(10'h200, 1'b0);
    wr(8'h01, 16'h0001);
    mode_encode_in = 1'b0;
    fq(10'h000, 1'b0);
    ce_in = 1'b0;
    wr(8'h01, 16'h0055);
    ce_in = 1'b1;
    rd(8'h01, 16'h0001);
    mode_encode_in = 1'b1;
    smp(10'h2cf, 1'b0);
    smp(10'h2d0, 1'b1);
    wr(8'h02, 16'h000a);
    wr(8'h03, 16'h0014);
    smp(10'h009, 1'b1);
    smp(10'h00a, 1'b0);
    smp(10'h014, 1'b0);
    smp(10'h015, 1'b1);
    wr(8'h04, 16'h0065);
    smp(10'h00f, 1'b1);
    wr(8'h04, 16'h0064);
    smp(10'h00f, 1'b0);
    frame_line_in = 10'h20d;
    smp(10'h00f, 1'b0);
    frame_line_in = 10'h20e;
    smp(10'h00f, 1'b1);
    mode_625_line_in = 1'b1;
    smp(10'h00f, 1'b0);
    mode_625_line_in = 1'b0;
    mode_encode_in = 1'b0;
    smp(10'h009, 1'b0);
    mode_encode_in = 1'b1;
    mode_quality_box_enable_in = 1'b1;
    smp(10'h00f, 1'b0);
    chk("outside", 16'h0001, {15'h0000, outside_box_out});
    field_line_in = 10'h0f3;
    smp(10'h00f, 1'b0);
    chk("outside", 16'h0000, {15'h0000, outside_box_out});
    field_line_in = 10'h0f4;
    smp(10'h00f, 1'b0);
    chk("outside", 16'h0001, {15'h0000, outside_box_out});
    mode_quality_box_enable_in = 1'b0;
    frame_line_in = 10'h064;
    wr(8'h02, 16'h001e);
    smp(10'h019, 1'b1);
    wr(8'h07, 16'h0010);
    wr(8'h08, 16'h0001);
    rd(8'h08, 16'h0001);
    pulse(1'b1);
    for (i = 0; i < 15; i++) pulse(1'b0);
    chk("limit", 16'h0000, {15'h0000, size_limit_reached_out});
    pulse(1'b0);
    chk("limit", 16'h0001, {15'h0000, size_limit_reached_out});
    wr(8'h09, 16'hf623);
    rd(8'h09, 16'h0623);
    chk("memory_error_flag_en", 16'h0001, {15'h0000, memory_error_detect_en_out});
    chk("contrast", 16'h0003, {13'h0000, background_contrast_out});
    for (i = 0; i < 4; i++)
    begin
      pulse(1'b1);
      chk("keep", {15'h0000, i % 3 == 0}, {15'h0000, field_keep_out});
    end
    field_pin_in = 1'b1;
    repeat (8) @(negedge core_clk_in);
    chk("field", 16'h0001, {15'h0000, field_indicator_out});
    wr(8'h09, 16'h062b);
    repeat (2) @(negedge core_clk_in);
    chk("field", 16'h0000, {15'h0000, field_indicator_out});
    mode_encode_in = 1'b0;
    pulse(1'b1);
    pulse(1'b1);
    chk("black", 16'h0001, {15'h0000, decode_black_field_out});
    wr(8'h09, 16'h0e2b);
    pulse(1'b1);
    chk("black", 16'h0000, {15'h0000, decode_black_field_out});
    complete_run;
  end
endmodule // tb
